//--- pmmc_mdio_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmmc_regs.svh"

module pmmc_mdio_slave #(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_mdc,
  input wire logic i_mdio,
  output logic o_mdio,
  output logic o_mdio_oe,
  output logic o_wr_stb,
  output logic [4:0] o_addr,
  output logic [15:0] o_wdata,
  input wire logic [15:0] i_rdata
);

  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  logic [2:0] mdc_sync_reg;
  logic [1:0] mdio_sync_reg;
  logic mdc_rise;
  logic bit_in;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mdc_sync_reg <= 3'h0;
      mdio_sync_reg <= 2'h3;
    end else begin
      mdc_sync_reg <= {mdc_sync_reg[1:0], i_mdc};
      mdio_sync_reg <= {mdio_sync_reg[0], i_mdio};
    end
  end

  assign mdc_rise = mdc_sync_reg[1] & ~mdc_sync_reg[2];
  assign bit_in = mdio_sync_reg[1];

  // -------------------------------------------------------------
  // frame engine
  // -------------------------------------------------------------
  pmmc_pkg::pmmc_mdio_state_t state_reg, state_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [15:0] shift_reg, shift_next;
  logic out_reg, out_next;
  logic oe_reg, oe_next;
  logic wr_reg, wr_next;
  logic [4:0] addr_reg, addr_next;
  logic [15:0] wdata_reg, wdata_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    out_next = out_reg;
    oe_next = oe_reg;
    wr_next = 1'b0;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    if (mdc_rise) begin
      unique case (state_reg)
        pmmc_pkg::PMMC_ST_IDLE: begin
          if (!bit_in) begin
            state_next = pmmc_pkg::PMMC_ST_START;
          end
        end
        pmmc_pkg::PMMC_ST_START: begin
          cnt_next = 5'h00;
          state_next = bit_in ? pmmc_pkg::PMMC_ST_HDR
                              : pmmc_pkg::PMMC_ST_IDLE;
        end
        pmmc_pkg::PMMC_ST_HDR: begin
          shift_next = {shift_reg[14:0], bit_in};
          cnt_next = cnt_reg + 5'h01;
          if (cnt_next == `PMMC_HDR_BITS) begin
            cnt_next = 5'h00;
            addr_next = shift_next[4:0];
            if (shift_next[9:5] != PHY_ADDR) begin
              state_next = pmmc_pkg::PMMC_ST_IDLE;
            end else if (shift_next[11:10] == `PMMC_OP_READ) begin
              state_next = pmmc_pkg::PMMC_ST_RD_TA;
            end else if (shift_next[11:10] == `PMMC_OP_WRITE) begin
              state_next = pmmc_pkg::PMMC_ST_WR_TA;
            end else begin
              state_next = pmmc_pkg::PMMC_ST_IDLE;
            end
          end
        end
        pmmc_pkg::PMMC_ST_RD_TA: begin
          // first turnaround bit sampled: drive the zero
          oe_next = 1'b1;
          out_next = 1'b0;
          shift_next = i_rdata;
          state_next = pmmc_pkg::PMMC_ST_RD;
        end
        pmmc_pkg::PMMC_ST_RD: begin
          if (cnt_reg == `PMMC_DATA_BITS) begin
            oe_next = 1'b0;
            out_next = 1'b1;
            state_next = pmmc_pkg::PMMC_ST_IDLE;
          end else begin
            out_next = shift_reg[15];
            shift_next = {shift_reg[14:0], 1'b0};
            cnt_next = cnt_reg + 5'h01;
          end
        end
        pmmc_pkg::PMMC_ST_WR_TA: begin
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == 5'h01) begin
            cnt_next = 5'h00;
            state_next = pmmc_pkg::PMMC_ST_WR;
          end
        end
        pmmc_pkg::PMMC_ST_WR: begin
          shift_next = {shift_reg[14:0], bit_in};
          cnt_next = cnt_reg + 5'h01;
          if (cnt_next == `PMMC_DATA_BITS) begin
            wdata_next = shift_next;
            wr_next = 1'b1;
            state_next = pmmc_pkg::PMMC_ST_IDLE;
          end
        end
        default: begin
          state_next = pmmc_pkg::PMMC_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg <= pmmc_pkg::PMMC_ST_IDLE;
      cnt_reg <= 5'h00;
      shift_reg <= 16'h0000;
      out_reg <= 1'b1;
      oe_reg <= 1'b0;
      wr_reg <= 1'b0;
      addr_reg <= 5'h00;
      wdata_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
      wr_reg <= wr_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
    end
  end

  assign o_mdio = out_reg;
  assign o_mdio_oe = oe_reg;
  assign o_wr_stb = wr_reg;
  assign o_addr = addr_reg;
  assign o_wdata = wdata_reg;

endmodule : pmmc_mdio_slave

`default_nettype wire

//--- pmmc_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmmc_regs.svh"

// Overview of operation
// - Three spaces: main 0-31, extended 16E-30E, general-purpose I/O 0G-30G; here 0-15 stay main on every page.
// - Main registers 16 to 30 reachable only while page register is zero.
// - Reserved bits ignore writes; their read value is undefined.
// - Bit 15 restores registers to defaults, then clears itself.
// - Bit 14 loops data back at current speed and bit 8 duplex.
// - Bit 12 enables auto-negotiation; resets to one.
// - Bit 11 powers the port down; resets to zero.
// - Bit 10 isolates: MAC-side outputs off, MAC-side inputs ignored.
// - Bit 9 restarts auto-negotiation and clears itself.
// - Bit 7 enables collision test; resets to zero.
// - Speed field bits 6 and 13: 10, 100, 1000, reserved; reset 1000.
// - Bit 5 used only with auto-negotiation off and full duplex.
// - Bits 4 to 0 reserved, read as zero.
module pmmc_mode_ctrl #(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_mdc,
  input wire logic i_mdio,
  output logic o_mdio,
  output logic o_mdio_oe,
  output logic o_loopback,
  output logic o_aneg_en,
  output logic o_power_down,
  output logic o_mac_out_en,
  output logic o_mac_in_en,
  output logic o_aneg_restart,
  output logic o_full_duplex,
  output logic o_coll_test,
  output logic [1:0] o_speed,
  output logic o_tx_without_link,
  output logic o_sw_reset
);

  localparam int SW_RESET_CYCLES =
    (`PMMC_SW_RESET_NS + `PMMC_CLK_PERIOD_NS - 1) / `PMMC_CLK_PERIOD_NS;
  localparam logic [7:0] SW_RESET_LAST = 8'(SW_RESET_CYCLES - 1);

  // -------------------------------------------------------------
  // address space decode
  // -------------------------------------------------------------
  function automatic pmmc_pkg::pmmc_space_t space_of(
    input logic [4:0] addr,
    input logic [15:0] page
  );
    if (addr <= `PMMC_ADDR_MAIN_LAST_STD || addr == `PMMC_ADDR_PAGE ||
        page == `PMMC_PAGE_MAIN) begin
      space_of = pmmc_pkg::PMMC_SPACE_MAIN;
    end else if (page == `PMMC_PAGE_EXT) begin
      space_of = pmmc_pkg::PMMC_SPACE_EXT;
    end else if (page == `PMMC_PAGE_GPIO) begin
      space_of = pmmc_pkg::PMMC_SPACE_GPIO;
    end else begin
      space_of = pmmc_pkg::PMMC_SPACE_NONE;
    end
  endfunction : space_of

  // -------------------------------------------------------------
  // management serial port
  // -------------------------------------------------------------
  logic wr_stb;
  logic [4:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;

  pmmc_mdio_slave #(
    .PHY_ADDR(PHY_ADDR)
  ) u_mdio (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_mdc(i_mdc),
    .i_mdio(i_mdio),
    .o_mdio(o_mdio),
    .o_mdio_oe(o_mdio_oe),
    .o_wr_stb(wr_stb),
    .o_addr(addr),
    .o_wdata(wdata),
    .i_rdata(rdata)
  );

  // -------------------------------------------------------------
  // register state
  // -------------------------------------------------------------
  logic [15:0] page_reg, page_next;
  logic loop_reg, loop_next;
  logic aneg_reg, aneg_next;
  logic pdown_reg, pdown_next;
  logic iso_reg, iso_next;
  logic restart_reg, restart_next;
  logic dup_reg, dup_next;
  logic coll_reg, coll_next;
  logic [1:0] speed_reg, speed_next;
  logic unidir_reg, unidir_next;
  logic srst_busy_reg, srst_busy_next;
  logic [7:0] srst_cnt_reg, srst_cnt_next;
  logic txnl_reg, txnl_next;
  logic macen_reg, macen_next;
  logic wr_mc;
  logic wr_page;
  logic [1:0] wr_speed;

  assign wr_mc = wr_stb && addr == `PMMC_ADDR_MODE_CTRL;
  assign wr_page = wr_stb && addr == `PMMC_ADDR_PAGE;
  assign wr_speed = {wdata[`PMMC_MC_SPEED_MSB], wdata[`PMMC_MC_SPEED_LSB]};

  always_comb begin
    page_next = page_reg;
    loop_next = loop_reg;
    aneg_next = aneg_reg;
    pdown_next = pdown_reg;
    iso_next = iso_reg;
    restart_next = 1'b0;
    dup_next = dup_reg;
    coll_next = coll_reg;
    speed_next = speed_reg;
    unidir_next = unidir_reg;
    srst_busy_next = srst_busy_reg;
    srst_cnt_next = srst_cnt_reg;
    if (srst_busy_reg) begin
      srst_cnt_next = srst_cnt_reg + 8'h01;
      if (srst_cnt_reg == SW_RESET_LAST) begin
        srst_busy_next = 1'b0;
      end
    end
    if (wr_mc && wdata[`PMMC_MC_SW_RESET]) begin
      // no sticky bits live here, so everything returns to default
      page_next = `PMMC_PAGE_RST;
      loop_next = `PMMC_RST_LOOPBACK;
      aneg_next = `PMMC_RST_ANEG_EN;
      pdown_next = `PMMC_RST_POWER_DOWN;
      iso_next = `PMMC_RST_ISOLATE;
      dup_next = `PMMC_RST_DUPLEX;
      coll_next = `PMMC_RST_COLL_TEST;
      speed_next = `PMMC_RST_SPEED;
      unidir_next = `PMMC_RST_UNIDIR;
      srst_busy_next = 1'b1;
      srst_cnt_next = 8'h00;
    end else if (wr_mc) begin
      loop_next = wdata[`PMMC_MC_LOOPBACK];
      aneg_next = wdata[`PMMC_MC_ANEG_EN];
      pdown_next = wdata[`PMMC_MC_POWER_DOWN];
      iso_next = wdata[`PMMC_MC_ISOLATE];
      restart_next = wdata[`PMMC_MC_ANEG_RESTART];
      dup_next = wdata[`PMMC_MC_DUPLEX];
      coll_next = wdata[`PMMC_MC_COLL_TEST];
      if (wr_speed != `PMMC_SPEED_RSVD) begin
        speed_next = wr_speed;
      end
      unidir_next = wdata[`PMMC_MC_UNIDIR];
    end else if (wr_page) begin
      page_next = wdata;
    end
    txnl_next = unidir_next & ~aneg_next & dup_next;
    macen_next = ~iso_next;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      page_reg <= `PMMC_PAGE_RST;
      loop_reg <= `PMMC_RST_LOOPBACK;
      aneg_reg <= `PMMC_RST_ANEG_EN;
      pdown_reg <= `PMMC_RST_POWER_DOWN;
      iso_reg <= `PMMC_RST_ISOLATE;
      restart_reg <= 1'b0;
      dup_reg <= `PMMC_RST_DUPLEX;
      coll_reg <= `PMMC_RST_COLL_TEST;
      speed_reg <= `PMMC_RST_SPEED;
      unidir_reg <= `PMMC_RST_UNIDIR;
      srst_busy_reg <= 1'b0;
      srst_cnt_reg <= 8'h00;
      txnl_reg <= 1'b0;
      macen_reg <= ~`PMMC_RST_ISOLATE;
    end else begin
      page_reg <= page_next;
      loop_reg <= loop_next;
      aneg_reg <= aneg_next;
      pdown_reg <= pdown_next;
      iso_reg <= iso_next;
      restart_reg <= restart_next;
      dup_reg <= dup_next;
      coll_reg <= coll_next;
      speed_reg <= speed_next;
      unidir_reg <= unidir_next;
      srst_busy_reg <= srst_busy_next;
      srst_cnt_reg <= srst_cnt_next;
      txnl_reg <= txnl_next;
      macen_reg <= macen_next;
    end
  end

  // -------------------------------------------------------------
  // read mux
  // -------------------------------------------------------------
  always_comb begin
    rdata = 16'h0000; // unimplemented and reserved read zero
    if (space_of(addr, page_reg) == pmmc_pkg::PMMC_SPACE_MAIN) begin
      if (addr == `PMMC_ADDR_MODE_CTRL) begin
        rdata[`PMMC_MC_SW_RESET] = srst_busy_reg;
        rdata[`PMMC_MC_LOOPBACK] = loop_reg;
        rdata[`PMMC_MC_SPEED_LSB] = speed_reg[0];
        rdata[`PMMC_MC_ANEG_EN] = aneg_reg;
        rdata[`PMMC_MC_POWER_DOWN] = pdown_reg;
        rdata[`PMMC_MC_ISOLATE] = iso_reg;
        rdata[`PMMC_MC_ANEG_RESTART] = restart_reg;
        rdata[`PMMC_MC_DUPLEX] = dup_reg;
        rdata[`PMMC_MC_COLL_TEST] = coll_reg;
        rdata[`PMMC_MC_SPEED_MSB] = speed_reg[1];
        rdata[`PMMC_MC_UNIDIR] = unidir_reg; // bits 4:0 stay zero
      end else if (addr == `PMMC_ADDR_PAGE) begin
        rdata = page_reg;
      end
    end
  end

  // -------------------------------------------------------------
  // control outputs
  // -------------------------------------------------------------
  assign o_loopback = loop_reg;
  assign o_aneg_en = aneg_reg;
  assign o_power_down = pdown_reg;
  assign o_mac_out_en = macen_reg;
  assign o_mac_in_en = macen_reg;
  assign o_aneg_restart = restart_reg;
  assign o_full_duplex = dup_reg;
  assign o_coll_test = coll_reg;
  assign o_speed = speed_reg;
  assign o_tx_without_link = txnl_reg;
  assign o_sw_reset = srst_busy_reg;

endmodule : pmmc_mode_ctrl

`default_nettype wire

//--- pmmc_mode_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module pmmc_mode_ctrl_monitor (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_mdc,
  input wire logic i_mdio,
  input wire logic o_mdio,
  input wire logic o_mdio_oe,
  input wire logic o_loopback,
  input wire logic o_aneg_en,
  input wire logic o_power_down,
  input wire logic o_mac_out_en,
  input wire logic o_mac_in_en,
  input wire logic o_aneg_restart,
  input wire logic o_full_duplex,
  input wire logic o_coll_test,
  input wire logic [1:0] o_speed,
  input wire logic o_tx_without_link,
  input wire logic o_sw_reset
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  localparam int SW_CYCLES = 100;
  logic [7:0] sw_cnt_reg;
  logic [7:0] sw_cnt_next;

  // ---------------------------------------------------------------
  // length of the soft reset pulse
  // ---------------------------------------------------------------
  always_comb begin
    sw_cnt_next = o_sw_reset ? sw_cnt_reg + 8'h01 : 8'h00;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sw_cnt_reg <= 8'h00;
    end else begin
      sw_cnt_reg <= sw_cnt_next;
    end
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  sequence dflt_s;
    o_aneg_en && (o_speed == 2'h2) && !o_loopback && !o_power_down &&
      o_mac_out_en && !o_full_duplex && !o_coll_test && !o_tx_without_link;
  endsequence

  sequence idle_s;
    !o_mdio_oe && o_mdio && !o_sw_reset;
  endsequence

  rst_dflt_a: assert property ($fell(i_srst) |-> dflt_s ##0 idle_s)
    else $error("outputs not at defaults after reset");
  sw_dflt_a: assert property ($rose(o_sw_reset) |-> ##[0:2] dflt_s)
    else $error("soft reset did not load defaults");
  sw_cnt_a: assert property (o_sw_reset |-> sw_cnt_reg < SW_CYCLES)
    else $error("soft reset pulse too long");
  sw_len_a: assert property (
    $fell(o_sw_reset) |-> sw_cnt_reg == SW_CYCLES)
    else $error("soft reset pulse length wrong");
  restart_pulse_a: assert property (o_aneg_restart |=> !o_aneg_restart)
    else $error("restart pulse longer than one cycle");
  isolate_pair_a: assert property (o_mac_out_en == o_mac_in_en)
    else $error("isolate enables disagree");
  tx_nolink_a: assert property (
    o_tx_without_link |-> !o_aneg_en && o_full_duplex)
    else $error("unidirectional active while ignored");
  speed_legal_a: assert property (o_speed != 2'h3)
    else $error("reserved speed code in use");
  ta_zero_a: assert property ($rose(o_mdio_oe) |-> !o_mdio)
    else $error("turnaround not driven low");
endmodule : pmmc_mode_ctrl_monitor

bind pmmc_mode_ctrl pmmc_mode_ctrl_monitor i_mon (
  .i_clk(i_clk), .i_srst(i_srst), .i_mdc(i_mdc), .i_mdio(i_mdio),
  .o_mdio(o_mdio), .o_mdio_oe(o_mdio_oe), .o_loopback(o_loopback),
  .o_aneg_en(o_aneg_en), .o_power_down(o_power_down),
  .o_mac_out_en(o_mac_out_en), .o_mac_in_en(o_mac_in_en),
  .o_aneg_restart(o_aneg_restart), .o_full_duplex(o_full_duplex),
  .o_coll_test(o_coll_test), .o_speed(o_speed),
  .o_tx_without_link(o_tx_without_link), .o_sw_reset(o_sw_reset)
);

`default_nettype wire

//--- pmmc_mode_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmmc_regs.svh"

module pmmc_mode_ctrl_tb;
  localparam logic [4:0] PHY = 5'h03;
  typedef struct packed {
    logic [15:0] wr;
    logic [15:0] rd;
  } pmmc_row_t;
  pmmc_row_t rows [8] = '{
    '{16'h1140, 16'h1140},
    '{16'h6100, 16'h6100},
    '{16'h0c80, 16'h0c80},
    '{16'h012f, 16'h0120},
    '{16'h1120, 16'h1120},
    '{16'h2020, 16'h2020},
    '{16'h2140, 16'h2100},
    '{16'h1340, 16'h1140}
  };
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic mdc, mdio, d_mdio, d_oe, lb, an, pd, mo, mi, ar, fd, ct, txl, swr;
  logic [1:0] spd;
  logic [15:0] rd;
  logic [15:0] obs;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_restart = 0;

  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    if (ar === 1'b1) n_restart <= n_restart + 1;
  end
  assign obs = {6'h00, lb, an, pd, mo, mi, fd, ct, spd, txl};

  pmmc_mode_ctrl #(.PHY_ADDR(PHY)) i_dut (
    .i_clk(i_clk), .i_srst(i_srst), .i_mdc(mdc), .i_mdio(mdio),
    .o_mdio(d_mdio), .o_mdio_oe(d_oe), .o_loopback(lb), .o_aneg_en(an),
    .o_power_down(pd), .o_mac_out_en(mo), .o_mac_in_en(mi),
    .o_aneg_restart(ar), .o_full_duplex(fd), .o_coll_test(ct),
    .o_speed(spd), .o_tx_without_link(txl), .o_sw_reset(swr)
  );
  pmmc_smi_host i_host (.i_clk(i_clk), .o_mdc(mdc), .o_mdio(mdio),
    .i_mdio(d_mdio), .i_mdio_oe(d_oe));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] exp_out(input logic [15:0] r);
    return {6'h00, r[14], r[12], r[11], ~r[10], ~r[10], r[8], r[7],
      r[6], r[13], r[5] & ~r[12] & r[8]};
  endfunction : exp_out

  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    i_host.smi_write(PHY, a, v);
  endtask : wr

  task automatic rdchk(input logic [4:0] a, input logic [15:0] e,
                       input string nm);
    i_host.smi_read(PHY, a, rd);
    check(nm, rd, e);
  endtask : rdchk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge i_clk);
    #1;
    i_srst = 1'b0;
    check("rst outs", obs, exp_out(16'h1040));
    check("rst mdio", {14'h0, d_oe, d_mdio}, 16'h0001);
    rdchk(`PMMC_ADDR_MODE_CTRL, 16'h1040, "rst reg0");
    foreach (rows[i]) begin
      wr(`PMMC_ADDR_MODE_CTRL, rows[i].wr);
      rdchk(`PMMC_ADDR_MODE_CTRL, rows[i].rd, "reg0");
      check("outs", obs, exp_out(rows[i].rd));
    end
    check("restart", 16'(n_restart), 16'h0001);
    i_host.smi_read(PHY, `PMMC_ADDR_MODE_CTRL, rd);
    wr(`PMMC_ADDR_MODE_CTRL, (rd | 16'h4000) & 16'hffe0);
    rdchk(`PMMC_ADDR_MODE_CTRL, 16'h5140, "rmw");
    wr(`PMMC_ADDR_PAGE, `PMMC_PAGE_EXT);
    rdchk(`PMMC_ADDR_PAGE, `PMMC_PAGE_EXT, "page");
    rdchk(5'h14, 16'h0000, "ext page");
    rdchk(5'h05, 16'h0000, "unmapped");
    wr(`PMMC_ADDR_PAGE, `PMMC_PAGE_GPIO);
    rdchk(5'h1e, 16'h0000, "gpio page");
    rdchk(`PMMC_ADDR_PAGE, `PMMC_PAGE_GPIO, "page gpio");
    wr(`PMMC_ADDR_MODE_CTRL, 16'h8000);
    check("swr on", {15'h0, swr}, 16'h0001);
    check("sw outs", obs, exp_out(16'h1040));
    i_host.tick(`PMMC_SW_RESET_NS / `PMMC_CLK_PERIOD_NS);
    check("swr off", {15'h0, swr}, 16'h0000);
    rdchk(`PMMC_ADDR_PAGE, `PMMC_PAGE_RST, "page rst");
    rdchk(`PMMC_ADDR_MODE_CTRL, 16'h1040, "sw reg0");
    i_host.smi_write(PHY ^ 5'h01, `PMMC_ADDR_MODE_CTRL, 16'h0800);
    rdchk(`PMMC_ADDR_MODE_CTRL, 16'h1040, "other phy");
    i_host.smi_read(PHY ^ 5'h01, `PMMC_ADDR_MODE_CTRL, rd);
    check("no answer", rd, 16'hffff);
    wr(`PMMC_ADDR_MODE_CTRL, 16'h4900);
    check("pre rst", obs, exp_out(16'h4900));
    @(posedge i_clk);
    #1;
    i_srst = 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    i_srst = 1'b0;
    check("mid rst", obs, exp_out(16'h1040));
    rdchk(`PMMC_ADDR_MODE_CTRL, 16'h1040, "mid reg0");
    report_and_stop();
  end

  initial begin
    #2000000;
    n_mismatch++;
    report_and_stop();
  end
endmodule : pmmc_mode_ctrl_tb

`default_nettype wire

//--- pmmc_pkg.sv
package pmmc_pkg;

  typedef enum logic [2:0] {
    PMMC_ST_IDLE = 3'b000,
    PMMC_ST_START = 3'b001,
    PMMC_ST_HDR = 3'b010,
    PMMC_ST_RD_TA = 3'b011,
    PMMC_ST_RD = 3'b100,
    PMMC_ST_WR_TA = 3'b101,
    PMMC_ST_WR = 3'b110
  } pmmc_mdio_state_t;

  typedef enum logic [1:0] {
    PMMC_SPACE_MAIN = 2'b00,
    PMMC_SPACE_EXT = 2'b01,
    PMMC_SPACE_GPIO = 2'b10,
    PMMC_SPACE_NONE = 2'b11
  } pmmc_space_t;

endpackage : pmmc_pkg

//--- pmmc_regs.svh
`ifndef PMMC_REGS_SVH
`define PMMC_REGS_SVH

// ---------------------------------------------------------------
// register addresses
// ---------------------------------------------------------------
`define PMMC_ADDR_MODE_CTRL 5'h00
`define PMMC_ADDR_MAIN_LAST_STD 5'h0f
`define PMMC_ADDR_PAGE 5'h1f

// ---------------------------------------------------------------
// page codes
// ---------------------------------------------------------------
`define PMMC_PAGE_MAIN 16'h0000
`define PMMC_PAGE_EXT 16'h0001
`define PMMC_PAGE_GPIO 16'h0010
`define PMMC_PAGE_RST 16'h0000

// ---------------------------------------------------------------
// mode control fields
// ---------------------------------------------------------------
`define PMMC_MC_SW_RESET 15
`define PMMC_MC_LOOPBACK 14
`define PMMC_MC_SPEED_LSB 13
`define PMMC_MC_ANEG_EN 12
`define PMMC_MC_POWER_DOWN 11
`define PMMC_MC_ISOLATE 10
`define PMMC_MC_ANEG_RESTART 9
`define PMMC_MC_DUPLEX 8
`define PMMC_MC_COLL_TEST 7
`define PMMC_MC_SPEED_MSB 6
`define PMMC_MC_UNIDIR 5

`define PMMC_RST_LOOPBACK 1'b0
`define PMMC_RST_ANEG_EN 1'b1
`define PMMC_RST_POWER_DOWN 1'b0
`define PMMC_RST_ISOLATE 1'b0
`define PMMC_RST_DUPLEX 1'b0
`define PMMC_RST_COLL_TEST 1'b0
`define PMMC_RST_SPEED 2'h2
`define PMMC_RST_UNIDIR 1'b0

`define PMMC_SPEED_10 2'h0
`define PMMC_SPEED_100 2'h1
`define PMMC_SPEED_1000 2'h2
`define PMMC_SPEED_RSVD 2'h3

// ---------------------------------------------------------------
// timing and frame constants
// ---------------------------------------------------------------
`define PMMC_CLK_PERIOD_NS 40
`define PMMC_SW_RESET_NS 4000
`define PMMC_OP_READ 2'h2
`define PMMC_OP_WRITE 2'h1
`define PMMC_HDR_BITS 5'h0c
`define PMMC_DATA_BITS 5'h10

`endif

//--- pmmc_smi_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmmc_regs.svh"

module pmmc_smi_host #(
  parameter int HALF = 8
) (
  input wire logic i_clk,
  output logic o_mdc,
  output logic o_mdio,
  input wire logic i_mdio,
  input wire logic i_mdio_oe
);
  logic drv_oe;
  logic drv_val;

  initial begin
    o_mdc = 1'b0;
    drv_oe = 1'b0;
    drv_val = 1'b1;
  end

  // pull-up holds the line high when nobody drives it
  assign o_mdio = i_mdio_oe ? i_mdio : (drv_oe ? drv_val : 1'b1);

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick

  task automatic send(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      o_mdc = 1'b0;
      drv_oe = 1'b1;
      drv_val = v[i];
      tick(HALF);
      o_mdc = 1'b1;
      tick(HALF);
    end
  endtask : send

  task automatic smi_write(input logic [4:0] phy, input logic [4:0] rg,
                           input logic [15:0] d);
    send({14'h0, 4'hf, 2'b01, `PMMC_OP_WRITE, phy, rg}, 18);
    send({14'h0, 2'b10, d}, 18);
    o_mdc = 1'b0;
    drv_oe = 1'b0;
    tick(2 * HALF);
  endtask : smi_write

  task automatic smi_read(input logic [4:0] phy, input logic [4:0] rg,
                          output logic [15:0] d);
    send({14'h0, 4'hf, 2'b01, `PMMC_OP_READ, phy, rg}, 18);
    drv_oe = 1'b0;
    for (int i = 0; i < 2; i++) begin
      o_mdc = 1'b0;
      tick(HALF);
      o_mdc = 1'b1;
      tick(HALF);
    end
    for (int i = 15; i >= 0; i--) begin
      o_mdc = 1'b0;
      tick(HALF);
      d[i] = o_mdio;
      o_mdc = 1'b1;
      tick(HALF);
    end
    o_mdc = 1'b0;
    tick(2 * HALF);
  endtask : smi_read
endmodule : pmmc_smi_host

`default_nettype wire
